// >>> tb/tb_teil_trap_wake.sv
// Testbench: bus, instruction stream and wake pin scenarios
`timescale 1ns/100ps
`default_nettype none
module tb_teil_trap_wake;
  import teil_pkg::*;
  localparam logic [3:0] CLR = 4'h8, VSEL = 4'h4, RET = 4'h2, POP = 4'h1;
  logic        clk = 1'b0, rst_n = 1'b0, rd_r = 1'b0, wr_r = 1'b0, fv = 1'b0, lp = 1'b0;
  logic [3:0]  addr = 4'h0, ex = 4'h0;
  logic [31:0] wd = 32'h0, rdat, got;
  logic [14:0] fpc = 15'h0, rpc, pval;
  logic [7:0]  fd = 8'h00, sp = 8'h00, instr, vlo, pins;
  logic        wreq, ack, irq, vv, pld, wk, wks;
  logic [7:0]  gen [4] = '{8'h01, 8'h01, 8'h04, 8'h01};
  logic [31:0] gct [4] = '{32'h1, 32'h2, 32'h3, 32'h3};
  int          fail_count = 0, n_compared = 0;
  // Small memory so a fetch past its end is cheap to reach
  teil_trap_wake #(.MEM_SIZE(4096)) DUT (
    .SYS_CLK_IN(clk), .ARST_N_IN(rst_n), .AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd_r),
    .AVS_WRITE_IN(wr_r), .AVS_WRITEDATA_IN(wd), .AVS_BYTEENABLE_IN(4'hF),
    .AVS_READDATA_OUT(rdat), .AVS_WAITREQUEST_OUT(wreq), .FETCH_VALID_IN(fv),
    .FETCH_PC_IN(fpc), .FETCH_DATA_IN(fd), .EXEC_CLEAR_PEND_IN(ex[3]),
    .EXEC_VECTOR_SEL_IN(ex[2]), .EXEC_RETURN_IN(ex[1]), .STACK_POP_IN(ex[0]),
    .STACK_PTR_IN(sp), .LOW_POWER_IN(lp), .WAKE_PINS_IN(pins), .INSTR_OUT(instr),
    .TRAP_ACK_OUT(ack), .TRAP_RET_PC_OUT(rpc), .IRQ_REQ_OUT(irq), .VEC_VALID_OUT(vv),
    .VEC_LO_OUT(vlo), .PC_LOAD_OUT(pld), .PC_LOAD_VAL_OUT(pval), .WAKE_OUT(wk),
    .WAKE_SERVICE_OUT(wks));
  teil_pin_model PIN (.clk_in(clk), .pins_out(pins));
  // 50 MHz clock
  always #10 clk = ~clk;
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Request held until waitrequest is sampled low; read data taken there
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr_r <= w;
    rd_r <= ~w;
    do @(posedge clk); while (wreq !== 1'b0);
    got = rdat;
    wr_r <= 1'b0;
    rd_r <= 1'b0;
  endtask
  // One-cycle fetch or execute pulses; outputs settle after the taking edge
  task automatic fetch(input logic [14:0] pc, input logic [7:0] d);
    @(posedge clk);
    fv <= 1'b1;
    fpc <= pc;
    fd <= d;
    @(posedge clk);
    fv <= 1'b0;
    #1;
  endtask
  task automatic op(input logic [3:0] m);
    @(posedge clk);
    ex <= m;
    @(posedge clk);
    ex <= 4'h0;
    #1;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic end_sim;
    if (fail_count == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    end_sim;
  end
  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    for (int a = 0; a < 16; a += 2) begin
      bus(1'b0, a[3:0], 32'h0);
      chk(got, 32'h0);
    end
    bus(1'b1, REG_WAKE_EDGE, 32'h0F);
    PIN.drive(8'hFF, 0);
    bus(1'b0, REG_WAKE_PEND, 32'h0);
    chk(got, 32'hF0);
    PIN.drive(8'h00, 2);
    bus(1'b0, REG_WAKE_PEND, 32'h0);
    chk(got, 32'hFF);
    bus(1'b1, REG_WAKE_PEND, 32'hFF);
    bus(1'b0, REG_WAKE_PEND, 32'h0);
    chk(got, 32'h0);
    // Request held back until every gate is open
    bus(1'b1, REG_WAKE_EDGE, 32'h0);
    PIN.drive(8'h03, 0);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, REG_WAKE_EN, {24'h0, gen[i]});
      bus(1'b1, REG_CTRL, gct[i]);
      tick(2);
      chk(32'(irq), 32'(i == 3));
    end
    fetch(15'h0123, TRAP_OPCODE);
    chk({17'h0, rpc}, 32'h0123);
    tick(2);
    chk(32'(irq), 32'h0);
    op(VSEL);
    chk(32'(vlo), 32'hFE);
    bus(1'b0, REG_CTRL, 32'h0);
    chk(got, 32'h3);
    op(CLR);
    op(CLR);
    op(RET);
    tick(2);
    chk(32'(irq), 32'h1);
    op(VSEL);
    chk(32'(vlo), 32'hE2);
    fetch(15'h0200, TRAP_OPCODE);
    chk(32'(ack), 32'h1);
    op(CLR);
    op(CLR);
    op(RET);
    fetch(15'h1000, 8'hA5);
    chk(32'(instr), 32'h0);
    chk(32'(ack), 32'h1);
    fetch(15'h0FFF, 8'hA5);
    chk(32'(instr), 32'hA5);
    chk(32'(ack), 32'h0);
    op(CLR);
    op(CLR);
    @(posedge clk) sp <= 8'h6F;
    op(POP);
    chk({16'h0, pld, pval}, 32'h0000FFFF);
    @(posedge clk) lp <= 1'b1;
    bus(1'b1, REG_CTRL, 32'h0);
    bus(1'b1, REG_WAKE_EN, 32'hFF);
    PIN.drive(8'hFF, 0);
    tick(1);
    chk({30'h0, wk, wks}, 32'h2);
    @(posedge clk) lp <= 1'b0;
    fetch(15'h0040, TRAP_OPCODE);
    @(posedge clk) rst_n <= 1'b0;
    @(posedge clk) rst_n <= 1'b1;
    op(VSEL);
    chk(32'(vlo), 32'hE0);
    end_sim;
  end
endmodule
`default_nettype wire

// >>> tb/teil_pin_model.sv
// Partner model: external pins driving the wake-up port
`timescale 1ns/100ps
`default_nettype none
module teil_pin_model (
  input  wire logic       clk_in,
  output var  logic [7:0] pins_out
);
  // Pins rest low and only move just after a clock edge
  initial pins_out = 8'h00;
  // Optional idle span, new levels, then time for the edge to be latched
  task automatic drive(input logic [7:0] v, input int slow);
    repeat (slow) @(posedge clk_in);
    @(posedge clk_in);
    pins_out <= v;
    repeat (3) @(posedge clk_in);
  endtask
endmodule
`default_nettype wire

// >>> tb/teil_trap_wake_asserts.sv
// Checker: concurrent properties of the trap and wake-up interrupt logic
`timescale 1ns/100ps
`default_nettype none
module teil_trap_wake_asserts
  import teil_pkg::*;
#(
  parameter int MEM_SIZE = 32768,
  parameter int PC_WIDTH = 15
) (
  input wire logic                SYS_CLK_IN,
  input wire logic                ARST_N_IN,
  input wire logic                FETCH_VALID_IN,
  input wire logic [PC_WIDTH-1:0] FETCH_PC_IN,
  input wire logic [7:0]          FETCH_DATA_IN,
  input wire logic                EXEC_CLEAR_PEND_IN,
  input wire logic                EXEC_VECTOR_SEL_IN,
  input wire logic                STACK_POP_IN,
  input wire logic [7:0]          STACK_PTR_IN,
  input wire logic [7:0]          INSTR_OUT,
  input wire logic                TRAP_ACK_OUT,
  input wire logic [PC_WIDTH-1:0] TRAP_RET_PC_OUT,
  input wire logic                IRQ_REQ_OUT,
  input wire logic                VEC_VALID_OUT,
  input wire logic [7:0]          VEC_LO_OUT,
  input wire logic                PC_LOAD_OUT,
  input wire logic [PC_WIDTH-1:0] PC_LOAD_VAL_OUT
);
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (!ARST_N_IN);
  // Shadow of the hidden flag; a fetch past memory reads as the trap opcode
  logic trap_fetch;
  logic pend_ff;
  assign trap_fetch = FETCH_VALID_IN &
                      (FETCH_DATA_IN == TRAP_OPCODE || FETCH_PC_IN >= MEM_SIZE);
  // New trap wins over a clear in the same cycle
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      pend_ff <= 1'b0;
    end else begin
      pend_ff <= trap_fetch | (pend_ff & ~EXEC_CLEAR_PEND_IN);
    end
  end
  sequence s_trap_taken; trap_fetch ##1 TRAP_ACK_OUT; endsequence
  property p_trap_ack; trap_fetch |=> TRAP_ACK_OUT; endproperty
  a_trap_ack: assert property (p_trap_ack) else $error("trap not acknowledged");
  property p_no_ack; !trap_fetch |=> !TRAP_ACK_OUT; endproperty
  a_no_ack: assert property (p_no_ack) else $error("spurious trap ack");
  property p_ret_pc; s_trap_taken |-> TRAP_RET_PC_OUT == $past(FETCH_PC_IN); endproperty
  a_ret_pc: assert property (p_ret_pc) else $error("wrong return address");
  property p_instr;
    FETCH_VALID_IN |=> INSTR_OUT == ($past(FETCH_PC_IN) >= MEM_SIZE ? 8'h00 : $past(FETCH_DATA_IN));
  endproperty
  a_instr: assert property (p_instr) else $error("wrong fetched byte");
  property p_stack;
    STACK_POP_IN && STACK_PTR_IN >= STACK_LIMIT_ADDR |=> PC_LOAD_OUT && PC_LOAD_VAL_OUT == STACK_UNDER_PC;
  endproperty
  a_stack: assert property (p_stack) else $error("no load on stack underflow");
  property p_block; pend_ff [*3] |-> !IRQ_REQ_OUT; endproperty
  a_block: assert property (p_block) else $error("request while trap pending");
  property p_vec_trap; EXEC_VECTOR_SEL_IN && pend_ff |=> VEC_VALID_OUT && VEC_LO_OUT == VEC_TRAP_LO; endproperty
  a_vec_trap: assert property (p_vec_trap) else $error("trap vector missed");
  property p_vec_clr; EXEC_VECTOR_SEL_IN && !pend_ff |=> VEC_VALID_OUT && VEC_LO_OUT != VEC_TRAP_LO; endproperty
  a_vec_clr: assert property (p_vec_clr) else $error("trap vector after clear");
  property p_vec_wake; EXEC_VECTOR_SEL_IN && !pend_ff && IRQ_REQ_OUT |=> VEC_LO_OUT == VEC_WAKE_LO; endproperty
  a_vec_wake: assert property (p_vec_wake) else $error("wrong wake vector");
endmodule
bind teil_trap_wake teil_trap_wake_asserts #(.MEM_SIZE(MEM_SIZE), .PC_WIDTH(PC_WIDTH)) u_chk (
  .SYS_CLK_IN(SYS_CLK_IN), .ARST_N_IN(ARST_N_IN), .FETCH_VALID_IN(FETCH_VALID_IN),
  .FETCH_PC_IN(FETCH_PC_IN), .FETCH_DATA_IN(FETCH_DATA_IN),
  .EXEC_CLEAR_PEND_IN(EXEC_CLEAR_PEND_IN), .EXEC_VECTOR_SEL_IN(EXEC_VECTOR_SEL_IN),
  .STACK_POP_IN(STACK_POP_IN), .STACK_PTR_IN(STACK_PTR_IN), .INSTR_OUT(INSTR_OUT),
  .TRAP_ACK_OUT(TRAP_ACK_OUT), .TRAP_RET_PC_OUT(TRAP_RET_PC_OUT), .IRQ_REQ_OUT(IRQ_REQ_OUT),
  .VEC_VALID_OUT(VEC_VALID_OUT), .VEC_LO_OUT(VEC_LO_OUT), .PC_LOAD_OUT(PC_LOAD_OUT),
  .PC_LOAD_VAL_OUT(PC_LOAD_VAL_OUT));
`default_nettype wire

// >>> verilog/teil_pkg.sv
// Package: constants for the trap and wake-up interrupt logic
package teil_pkg;
  // Register offsets (byte addresses, one word each)
  localparam logic [3:0] REG_WAKE_EN    = 4'h0;
  localparam logic [3:0] REG_WAKE_EDGE  = 4'h4;
  localparam logic [3:0] REG_WAKE_PEND  = 4'h8;
  localparam logic [3:0] REG_CTRL       = 4'hC;
  // Control register fields
  localparam int CTRL_GIE_BIT  = 0;
  localparam int CTRL_WAKE_PORT_GROUP_IRQ_ENABLE_BIT = 1;
  localparam int CTRL_TRAP_BIT = 2;
  // Reset values
  localparam logic [7:0] WAKE_EN_RST   = 8'h00;
  localparam logic [7:0] WAKE_EDGE_RST = 8'h00;
  localparam logic [7:0] WAKE_PEND_RST = 8'h00;
  // Opcodes and vectors
  localparam logic [7:0]  TRAP_OPCODE      = 8'h00;
  localparam logic [7:0]  VEC_TRAP_LO      = 8'hFE;
  localparam logic [7:0]  VEC_WAKE_LO      = 8'hE2;
  localparam logic [7:0]  VEC_DEFAULT_LO   = 8'hE0;
  localparam logic [14:0] STACK_UNDER_PC   = 15'h7FFF;
  localparam logic [7:0]  STACK_LIMIT_ADDR = 8'h6F;
  localparam logic [7:0]  UNUSED_MEM_BYTE  = 8'h00;
  // Vector select engine states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_BUSY = 3'b010,
    ST_DONE = 3'b100
  } teil_state_t;
endpackage

// >>> verilog/teil_trap_wake.sv
// Module: software trap pending logic and wake-up port edge interrupts
`timescale 1ns/100ps
`default_nettype none

module teil_trap_wake
  import teil_pkg::*;
#(
  parameter int NPINS    = 8,
  parameter int PC_WIDTH = 15,
  parameter int MEM_SIZE = 32768
) (
  input  wire logic                SYS_CLK_IN,
  input  wire logic                ARST_N_IN,
  // Avalon-MM slave
  input  wire logic [3:0]          AVS_ADDRESS_IN,
  input  wire logic                AVS_READ_IN,
  input  wire logic                AVS_WRITE_IN,
  input  wire logic [31:0]         AVS_WRITEDATA_IN,
  input  wire logic [3:0]          AVS_BYTEENABLE_IN,
  output logic [31:0]              AVS_READDATA_OUT,
  output logic                     AVS_WAITREQUEST_OUT,
  // Instruction stream from the core
  input  wire logic                FETCH_VALID_IN,
  input  wire logic [PC_WIDTH-1:0] FETCH_PC_IN,
  input  wire logic [7:0]          FETCH_DATA_IN,
  input  wire logic                EXEC_CLEAR_PEND_IN,
  input  wire logic                EXEC_VECTOR_SEL_IN,
  input  wire logic                EXEC_RETURN_IN,
  input  wire logic                STACK_POP_IN,
  input  wire logic [7:0]          STACK_PTR_IN,
  input  wire logic                LOW_POWER_IN,
  // Wake-up port pins
  input  wire logic [NPINS-1:0]    WAKE_PINS_IN,
  // Outputs to the core
  output logic [7:0]               INSTR_OUT,
  output logic                     TRAP_ACK_OUT,
  output logic [PC_WIDTH-1:0]      TRAP_RET_PC_OUT,
  output logic                     IRQ_REQ_OUT,
  output logic                     VEC_VALID_OUT,
  output logic [7:0]               VEC_LO_OUT,
  output logic                     PC_LOAD_OUT,
  output logic [PC_WIDTH-1:0]      PC_LOAD_VAL_OUT,
  output logic                     WAKE_OUT,
  output logic                     WAKE_SERVICE_OUT
);

  logic [NPINS-1:0]    wake_pin_irq_enable_reg_ff;
  logic [NPINS-1:0]    wake_pin_edge_select_reg_ff;
  logic [NPINS-1:0]    wake_pin_pending_reg_ff;
  logic [NPINS-1:0]    pins_prev_ff;
  logic                global_irq_enable_ff;
  logic                wake_port_group_irq_enable_ff;
  logic                trap_pending_flag_ff;
  logic                in_service_ff;
  logic                ack_phase_ff;
  logic [NPINS-1:0]    edge_hit;
  logic [NPINS-1:0]    nxt_pend;
  logic                trap_fetch;
  logic                wake_req;
  logic                wr_en;
  logic                rd_en;
  logic                bus_take;
  logic                vsel_take;
  logic                wake_any;
  logic [7:0]          fetched_byte;
  teil_state_t         state_ff;

  // A request is taken on its first edge; waitrequest drops for the next one
  assign bus_take = (AVS_READ_IN || AVS_WRITE_IN) && !ack_phase_ff;

  // Writes land on the edge at which the master sees waitrequest low
  assign wr_en = AVS_WRITE_IN && ack_phase_ff;

  // Read data captured on the taking edge, so it stands when the master looks
  assign rd_en = AVS_READ_IN && !ack_phase_ff;

  // Only an idle engine accepts a vector select; a repeat pulse is dropped
  assign vsel_take = EXEC_VECTOR_SEL_IN && (state_ff == ST_IDLE);

  // Any enabled pin pending, before the group and global enables
  // Also the wake source: a halted core wakes even with delivery masked
  assign wake_any = |(wake_pin_pending_reg_ff & wake_pin_irq_enable_reg_ff);

  // Beyond the fitted memory the bus floats to zero, decoding as a trap
  assign fetched_byte = (int'(FETCH_PC_IN) >= MEM_SIZE) ? UNUSED_MEM_BYTE
                                                        : FETCH_DATA_IN;
  assign trap_fetch = FETCH_VALID_IN && (fetched_byte == TRAP_OPCODE);

  // Edge detect per pin, polarity chosen by the edge select bit
  assign edge_hit = (wake_pin_edge_select_reg_ff & pins_prev_ff & ~WAKE_PINS_IN)
                  | (~wake_pin_edge_select_reg_ff & ~pins_prev_ff & WAKE_PINS_IN);

  // Maskable request: any pin pending and enabled, group on; global and trap gate it at IRQ_REQ_OUT
  assign wake_req = wake_any
                    && wake_port_group_irq_enable_ff;

  // Bus handshake: one wait cycle, answer on the second edge
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      ack_phase_ff <= 1'b0;
    end else begin
      ack_phase_ff <= bus_take;
    end
  end

  // Waitrequest low for one cycle per access; high in reset and while idle
  // A master that holds its request sees exactly one wait state
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      AVS_WAITREQUEST_OUT <= 1'b1;
    end else begin
      AVS_WAITREQUEST_OUT <= !bus_take;
    end
  end

  // Read data; trap flag deliberately absent from the map
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      AVS_READDATA_OUT <= 32'h0000_0000;
    end else if (rd_en) begin
      case (AVS_ADDRESS_IN)
        REG_WAKE_EN:   AVS_READDATA_OUT <= {{(32-NPINS){1'b0}}, wake_pin_irq_enable_reg_ff};
        REG_WAKE_EDGE: AVS_READDATA_OUT <= {{(32-NPINS){1'b0}}, wake_pin_edge_select_reg_ff};
        REG_WAKE_PEND: AVS_READDATA_OUT <= {{(32-NPINS){1'b0}}, wake_pin_pending_reg_ff};
        REG_CTRL:      AVS_READDATA_OUT <= {30'h0000_0000, wake_port_group_irq_enable_ff,
                                            global_irq_enable_ff};
        default:       AVS_READDATA_OUT <= 32'h0000_0000;
      endcase
    end
  end

  // Per-pin enables; every field sits in lane 0, other lanes are ignored
  // A disabled pin still latches its edge, so enabling it later fires at once
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      wake_pin_irq_enable_reg_ff <= WAKE_EN_RST;
    end else if (wr_en && AVS_BYTEENABLE_IN[0] && AVS_ADDRESS_IN == REG_WAKE_EN) begin
      wake_pin_irq_enable_reg_ff <= AVS_WRITEDATA_IN[NPINS-1:0];
    end
  end

  // Per-pin edge polarity: 0 rising, 1 falling
  // Changing it while a pin sits high or low does not create an edge
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      wake_pin_edge_select_reg_ff <= WAKE_EDGE_RST;
    end else if (wr_en && AVS_BYTEENABLE_IN[0] && AVS_ADDRESS_IN == REG_WAKE_EDGE) begin
      wake_pin_edge_select_reg_ff <= AVS_WRITEDATA_IN[NPINS-1:0];
    end
  end

  // Group enable for the wake port; the global enable has its own process
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      wake_port_group_irq_enable_ff <= 1'b0;
    end else if (wr_en && AVS_BYTEENABLE_IN[0] && AVS_ADDRESS_IN == REG_CTRL) begin
      wake_port_group_irq_enable_ff <= AVS_WRITEDATA_IN[CTRL_WAKE_PORT_GROUP_IRQ_ENABLE_BIT];
    end
  end

  // Global enable: software sets, taking a maskable interrupt clears, return sets
  // A trap leaves it alone; the hidden flag does the blocking instead
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      global_irq_enable_ff <= 1'b0;
    end else if (wr_en && AVS_BYTEENABLE_IN[0] && AVS_ADDRESS_IN == REG_CTRL) begin
      global_irq_enable_ff <= AVS_WRITEDATA_IN[CTRL_GIE_BIT];
    end else if (IRQ_REQ_OUT && EXEC_VECTOR_SEL_IN && !trap_pending_flag_ff) begin
      global_irq_enable_ff <= 1'b0;
    end else if (EXEC_RETURN_IN) begin
      global_irq_enable_ff <= 1'b1;
    end
  end

  // Pin history for edge detection
  // Resets low, so a pin already high at release reads as a rising edge
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      pins_prev_ff <= '0;
    end else begin
      pins_prev_ff <= WAKE_PINS_IN;
    end
  end

  // Pending latches: write one to clear, a fresh edge wins over the clear
  // Losing an edge would strand a halted core, so the set has priority
  always_comb begin
    nxt_pend = wake_pin_pending_reg_ff;
    if (wr_en && AVS_BYTEENABLE_IN[0] && AVS_ADDRESS_IN == REG_WAKE_PEND) begin
      nxt_pend = nxt_pend & ~AVS_WRITEDATA_IN[NPINS-1:0];
    end
    nxt_pend = nxt_pend | edge_hit;
  end

  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      wake_pin_pending_reg_ff <= WAKE_PEND_RST;
    end else begin
      wake_pin_pending_reg_ff <= nxt_pend;
    end
  end

  // Trap flag: set on fetch wins over the clear instruction
  // Kept off the bus map, so software cannot fake or hide a trap
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      trap_pending_flag_ff <= 1'b0;
    end else if (trap_fetch) begin
      trap_pending_flag_ff <= 1'b1;
    end else if (EXEC_CLEAR_PEND_IN) begin
      trap_pending_flag_ff <= 1'b0;
    end
  end

  // Instruction register feed, zero beyond the fitted memory
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      INSTR_OUT <= TRAP_OPCODE;
    end else begin
      INSTR_OUT <= fetched_byte;
    end
  end

  // Immediate trap acknowledge, no enable is consulted
  // One cycle wide; the core must act on it in that cycle
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      TRAP_ACK_OUT <= 1'b0;
    end else begin
      TRAP_ACK_OUT <= trap_fetch;
    end
  end

  // Return address is the trapping opcode itself, held until the next trap
  // A plain return therefore traps again; handlers must skip or restart
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      TRAP_RET_PC_OUT <= '0;
    end else if (trap_fetch) begin
      TRAP_RET_PC_OUT <= FETCH_PC_IN;
    end
  end

  // Maskable request to the core, blocked by trap and by an active routine
  // Registered, so it trails a fresh trap by one cycle
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      IRQ_REQ_OUT <= 1'b0;
    end else begin
      IRQ_REQ_OUT <= wake_req && global_irq_enable_ff && !trap_pending_flag_ff
                     && !in_service_ff;
    end
  end

  // Maskable routine in progress until return
  // No nesting of maskable routines; only the trap gets through
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      in_service_ff <= 1'b0;
    end else if (EXEC_VECTOR_SEL_IN && !trap_pending_flag_ff && IRQ_REQ_OUT) begin
      in_service_ff <= 1'b1;
    end else if (EXEC_RETURN_IN) begin
      in_service_ff <= 1'b0;
    end
  end

  // Vector select engine: one answer per instruction
  // The done state swallows a select in the cycle after an accepted one
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      state_ff <= ST_IDLE;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (EXEC_VECTOR_SEL_IN) begin
            state_ff <= ST_DONE;
          end
        end
        ST_DONE: begin
          state_ff <= ST_IDLE;
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // Valid pulse for exactly one cycle after an accepted select
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      VEC_VALID_OUT <= 1'b0;
    end else begin
      VEC_VALID_OUT <= vsel_take;
    end
  end

  // Arbitration: trap first, then wake port, else the default entry
  // The low byte stands until the next accepted select
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      VEC_LO_OUT <= VEC_DEFAULT_LO;
    end else if (vsel_take) begin
      if (trap_pending_flag_ff) begin
        VEC_LO_OUT <= VEC_TRAP_LO;
      end else if (IRQ_REQ_OUT) begin
        VEC_LO_OUT <= VEC_WAKE_LO;
      end else begin
        VEC_LO_OUT <= VEC_DEFAULT_LO;
      end
    end
  end

  // Stack underflow forces the top of program memory into the PC
  // If that location is blank the next fetch reads zero and traps
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      PC_LOAD_OUT <= 1'b0;
    end else begin
      PC_LOAD_OUT <= STACK_POP_IN && (STACK_PTR_IN >= STACK_LIMIT_ADDR);
    end
  end

  // Load value is fixed; it only matters while the load pulse stands
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      PC_LOAD_VAL_OUT <= '0;
    end else begin
      PC_LOAD_VAL_OUT <= STACK_UNDER_PC[PC_WIDTH-1:0];
    end
  end

  // Wake from low power on any enabled pending pin, even with delivery masked
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      WAKE_OUT <= 1'b0;
    end else begin
      WAKE_OUT <= LOW_POWER_IN && wake_any;
    end
  end

  // Service first only if the request passes the global enable and no trap is pending; else resume in line
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      WAKE_SERVICE_OUT <= 1'b0;
    end else begin
      WAKE_SERVICE_OUT <= LOW_POWER_IN && wake_req && global_irq_enable_ff
                          && !trap_pending_flag_ff;
    end
  end

endmodule

`default_nettype wire
